//--- rtl/rfe_pkg.sv
// Constants and types shared by the remote command front end
package rfe_pkg;

  // Clock and serial line settings handed to the UART blocks
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_VIRTUAL_SERIAL_PORT = 460_800;
  localparam int unsigned BAUD_LEGACY = 115_200;
  localparam logic [3:0] UART_DATA_BITS = 4'h8;
  localparam logic [1:0] UART_START_BITS = 2'h1;
  localparam logic [1:0] UART_STOP_BITS = 2'h1;
  localparam logic UART_PARITY_EN = 1'b0;
  localparam logic UART_FLOW_EN = 1'b0;
  localparam logic [15:0] VIRTUAL_SERIAL_PORT_BIT_CYCLES =
    16'(CLK_HZ / BAUD_VIRTUAL_SERIAL_PORT);
  localparam logic [15:0] LEGACY_BIT_CYCLES = 16'(CLK_HZ / BAUD_LEGACY);

  // ASCII bytes
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // Sources: two serial ports, then one per network connection
  localparam int unsigned SRC_W = 4;
  localparam int unsigned CONN_W = 3;
  localparam int unsigned N_CONN = 8;
  localparam logic [SRC_W-1:0] SRC_VIRTUAL_SERIAL_PORT = 4'h0;
  localparam logic [SRC_W-1:0] SRC_LEGACY = 4'h1;
  localparam logic [SRC_W-1:0] SRC_NET_BASE = 4'h8;

  // Network ports that are accepted
  localparam logic [15:0] PORT_TELNET = 16'h0017;
  localparam logic [15:0] PORT_CMD = 16'h1C0C;
  localparam logic [15:0] PORT_RAW = 16'h1C11;

  // Status and error
  localparam logic [15:0] ERR_INPUT_OVERFLOW = 16'hFED1;
  localparam int unsigned ESR_OPC_BIT = 0;
  localparam int unsigned ESR_EXE_BIT = 4;
  localparam logic [7:0] ESR_RST = 8'h80;

  // Command line and queue
  localparam int unsigned CMD_BYTES = 16;
  localparam int unsigned LEN_W = 5;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam logic [LEN_W-1:0] LEN_OPC = 5'h04;
  localparam logic [LEN_W-1:0] LEN_OPCQ = 5'h05;
  localparam logic [31:0] TXT_OPC = 32'h43504F2A;
  localparam logic [39:0] TXT_OPCQ = 40'h3F43504F2A;

  // Greeting sent on the command port, first byte in the top bits
  localparam int unsigned GREET_LEN = 22;
  localparam logic [GREET_LEN*8-1:0] GREET_TEXT =
    {"IP Interface", CH_CR, CH_LF, "Hello.", CH_CR, CH_LF};

  typedef enum logic [1:0] {
    KIND_GEN = 2'b00,
    KIND_OPC = 2'b01,
    KIND_OPCQ = 2'b10
  } rfe_kind_t;

  typedef struct packed {
    logic [SRC_W-1:0] src;
    rfe_kind_t kind;
    logic [LEN_W-1:0] len;
    logic [CMD_BYTES*8-1:0] text;
  } rfe_entry_t;

endpackage : rfe_pkg

//--- rtl/rfe_cq_if.sv
// Push and pop channel between the line parser and the command queue
interface rfe_cq_if;
  import rfe_pkg::*;
  logic push_valid;
  rfe_entry_t push_entry;
  logic full;
  logic pop_valid;
  rfe_entry_t pop_entry;
  logic pop_ready;

  modport queue (
    input push_valid, push_entry, pop_ready,
    output full, pop_valid, pop_entry
  );
  modport user (
    output push_valid, push_entry, pop_ready,
    input full, pop_valid, pop_entry
  );
endinterface : rfe_cq_if

//--- rtl/rfe_cmd_queue.sv
// In-order command queue with a parameter depth
module rfe_cmd_queue
  import rfe_pkg::*;
#(
  parameter int unsigned DEPTH = QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Queue channel
  rfe_cq_if.queue q
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    rfe_entry_t [DEPTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } rfe_q_state_t;

  rfe_q_state_t s_q;
  rfe_q_state_t s_d;
  logic do_push;
  logic do_pop;

  // Full only when every slot holds an unexecuted command
  assign q.full = (s_q.count == (PW+1)'(DEPTH));
  assign q.pop_valid = (s_q.count != '0);
  assign q.pop_entry = s_q.mem[s_q.rptr];
  // A push into a full queue is simply not stored
  assign do_push = q.push_valid && !q.full;
  assign do_pop = q.pop_valid && q.pop_ready;

  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.mem[s_q.wptr] = q.push_entry;
      s_d.wptr = (s_q.wptr == PW'(DEPTH - 1)) ? '0 : s_q.wptr + 1'b1;
    end
    if (do_pop) begin
      s_d.rptr = (s_q.rptr == PW'(DEPTH - 1)) ? '0 : s_q.rptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (do_pop && !do_push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

endmodule : rfe_cmd_queue

//--- rtl/rfe_remote_front_end.sv
// Remote command front end: line parsing, queueing, replies, connections
//
// Functional notes
// - Command arriving at a full queue is dropped; error -303 reported.
// - Operation-complete command is queued and runs in order.
// - Executing operation-complete command sets event register bit 0.
// - Operation-complete query replies "1" CR LF, leaves event bit alone.
// - Each reply goes only to the interface its query came from.
// - Virtual serial port runs 460800 baud, 8N1, no flow control.
// - Legacy serial port runs fixed 115200 baud, 8N1, no flow control.
// - Input is ASCII; keywords match regardless of letter case.
// - Every transmission ends with CR then LF.
// - CR, LF, CR LF, LF CR or semicolon ends a command.
// - Received characters are never echoed back.
// - Network connections accepted only on ports 23, 7180, 7185.
// - New port 7180 connection gets a fixed two-line greeting.
// - Several connections allowed on port 7180 and on port 23.
// - Display broadcast goes only to newest port 23 connection.
// - Port 7185 sends no greeting and allows several connections.
// - Overflow also sets the execution error bit, weight 16.
module rfe_remote_front_end
  import rfe_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Received bytes from serial ports and network connections
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [SRC_W-1:0] rx_src_i,
  // Network connection events
  input wire logic conn_open_i,
  input wire logic conn_close_i,
  input wire logic [15:0] conn_port_i,
  input wire logic [CONN_W-1:0] conn_id_i,
  output logic conn_accept_o,
  output logic conn_reject_o,
  // Display broadcast target
  output logic bcast_valid_o,
  output logic [CONN_W-1:0] bcast_conn_o,
  // Generic command execution
  output logic exec_valid_o,
  output logic [SRC_W-1:0] exec_src_o,
  output logic [LEN_W-1:0] exec_len_o,
  output logic [CMD_BYTES*8-1:0] exec_text_o,
  input wire logic exec_ready_i,
  input wire logic exec_reply_i,
  // Reply bytes from the executor
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_data_i,
  input wire logic rsp_last_i,
  output logic rsp_ready_o,
  // Transmitted bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic [SRC_W-1:0] tx_dst_o,
  input wire logic tx_ready_i,
  // Status
  output logic [7:0] esr_o,
  input wire logic esr_clear_i,
  output logic err_valid_o,
  output logic [15:0] err_code_o,
  // Serial port configuration
  output logic [15:0] virtual_serial_port_bit_cycles_o,
  output logic [15:0] legacy_bit_cycles_o,
  output logic [7:0] uart_frame_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_RSP = 3'b010,
    ST_ONE = 3'b011,
    ST_CR = 3'b100,
    ST_LF = 3'b101,
    ST_GREET = 3'b110
  } rfe_state_t;

  typedef struct packed {
    rfe_state_t st;
    logic [CMD_BYTES*8-1:0] line;
    logic [LEN_W-1:0] len;
    logic [SRC_W-1:0] line_src;
    rfe_entry_t cur;
    logic [7:0] esr;
    logic err;
    logic acc;
    logic rej;
    logic [N_CONN-1:0] greet;
    logic [LEN_W-1:0] gidx;
    logic bc_valid;
    logic [CONN_W-1:0] bc_id;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [SRC_W-1:0] tx_dst;
  } rfe_main_state_t;

  rfe_main_state_t s_q;
  rfe_main_state_t s_d;

  rfe_cq_if cq ();

  rfe_cmd_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .q(cq.queue)
  );

  logic is_term;
  logic [7:0] folded;
  logic can_load;
  rfe_kind_t line_kind;
  logic [CONN_W-1:0] greet_sel;
  logic greet_any;

  // Terminators; an empty line is dropped, which folds CR LF and LF CR
  assign is_term = (rx_data_i == CH_CR) || (rx_data_i == CH_LF) ||
                   (rx_data_i == CH_SEMI);

  // Upper-case fold so keyword matching ignores case
  assign folded = ((rx_data_i >= CH_LOW_A) && (rx_data_i <= CH_LOW_Z)) ?
                  (rx_data_i & ~CASE_BIT) : rx_data_i;

  // Output byte slot is free or is being taken this cycle
  assign can_load = !s_q.tx_valid || tx_ready_i;

  always_comb begin
    line_kind = KIND_GEN;
    if (s_q.len == LEN_OPC && s_q.line[31:0] == TXT_OPC) begin
      line_kind = KIND_OPC;
    end else if (s_q.len == LEN_OPCQ && s_q.line[39:0] == TXT_OPCQ) begin
      line_kind = KIND_OPCQ;
    end
  end

  // Lowest connection still owed its greeting
  always_comb begin
    greet_sel = '0;
    greet_any = 1'b0;
    for (int i = N_CONN - 1; i >= 0; i--) begin
      if (s_q.greet[i]) begin
        greet_sel = CONN_W'(i);
        greet_any = 1'b1;
      end
    end
  end

  // Completed line goes to the queue with its kind and source
  always_comb begin
    cq.push_valid = ce_i && rx_valid_i && is_term && (s_q.len != '0);
    cq.push_entry.src = s_q.line_src;
    cq.push_entry.kind = line_kind;
    cq.push_entry.len = s_q.len;
    cq.push_entry.text = s_q.line;
  end

  always_comb begin
    s_d = s_q;
    s_d.err = 1'b0;
    s_d.acc = 1'b0;
    s_d.rej = 1'b0;
    cq.pop_ready = 1'b0;
    rsp_ready_o = 1'b0;
    if (s_q.tx_valid && tx_ready_i) begin
      s_d.tx_valid = 1'b0;
    end

    // Status register: clear first, so any set in this cycle wins
    if (esr_clear_i) begin
      s_d.esr = '0;
    end

    // Line assembly
    if (rx_valid_i) begin
      if (is_term) begin
        s_d.len = '0;
        s_d.line = '0;
        if (cq.push_valid && cq.full) begin
          s_d.err = 1'b1;
          s_d.esr[ESR_EXE_BIT] = 1'b1;
        end
      end else begin
        if (s_q.len == '0) begin
          s_d.line_src = rx_src_i;
        end
        // Bytes past the line buffer are discarded; the line still counts
        if (s_q.len < LEN_W'(CMD_BYTES)) begin
          s_d.line[8*s_q.len +: 8] = folded;
          s_d.len = s_q.len + 1'b1;
        end
      end
    end

    // Connection bookkeeping
    if (conn_close_i) begin
      s_d.greet[conn_id_i] = 1'b0;
      if (s_q.bc_valid && s_q.bc_id == conn_id_i) begin
        s_d.bc_valid = 1'b0;
      end
    end
    if (conn_open_i) begin
      // Only the three listening ports answer; any number per port
      if (conn_port_i == PORT_TELNET || conn_port_i == PORT_CMD ||
          conn_port_i == PORT_RAW) begin
        s_d.acc = 1'b1;
      end else begin
        s_d.rej = 1'b1;
      end
      if (conn_port_i == PORT_CMD) begin
        s_d.greet[conn_id_i] = 1'b1;
      end
      if (conn_port_i == PORT_TELNET) begin
        // Newest telnet connection takes over the broadcast
        s_d.bc_valid = 1'b1;
        s_d.bc_id = conn_id_i;
      end
    end

    // Execution and transmit sequencer; only replies and greetings
    // ever reach the transmitter, received bytes never do
    unique case (s_q.st)
      ST_IDLE: begin
        if (greet_any) begin
          s_d.st = ST_GREET;
          s_d.gidx = '0;
          s_d.cur.src = SRC_NET_BASE | SRC_W'(greet_sel);
          s_d.greet[greet_sel] = 1'b0;
        end else if (cq.pop_valid) begin
          cq.pop_ready = 1'b1;
          s_d.cur = cq.pop_entry;
          unique case (cq.pop_entry.kind)
            KIND_OPC: begin
              s_d.esr[ESR_OPC_BIT] = 1'b1;
            end
            KIND_OPCQ: begin
              s_d.st = ST_ONE;
            end
            default: begin
              s_d.st = ST_EXEC;
            end
          endcase
        end
      end
      ST_EXEC: begin
        if (exec_ready_i) begin
          s_d.st = exec_reply_i ? ST_RSP : ST_IDLE;
        end
      end
      ST_RSP: begin
        rsp_ready_o = can_load;
        if (rsp_valid_i && can_load) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = rsp_data_i;
          s_d.tx_dst = s_q.cur.src;
          if (rsp_last_i) begin
            s_d.st = ST_CR;
          end
        end
      end
      ST_ONE: begin
        if (can_load) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = CH_ONE;
          s_d.tx_dst = s_q.cur.src;
          s_d.st = ST_CR;
        end
      end
      ST_CR: begin
        if (can_load) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = CH_CR;
          s_d.tx_dst = s_q.cur.src;
          s_d.st = ST_LF;
        end
      end
      ST_LF: begin
        if (can_load) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = CH_LF;
          s_d.tx_dst = s_q.cur.src;
          s_d.st = ST_IDLE;
        end
      end
      ST_GREET: begin
        if (can_load) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data =
            GREET_TEXT[8*(GREET_LEN-1-int'(s_q.gidx)) +: 8];
          s_d.tx_dst = s_q.cur.src;
          s_d.gidx = s_q.gidx + 1'b1;
          // The greeting text carries its own CR LF endings
          if (s_q.gidx == LEN_W'(GREET_LEN - 1)) begin
            s_d.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.esr <= ESR_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign conn_accept_o = s_q.acc;
  assign conn_reject_o = s_q.rej;
  assign bcast_valid_o = s_q.bc_valid;
  assign bcast_conn_o = s_q.bc_id;
  assign exec_valid_o = (s_q.st == ST_EXEC);
  assign exec_src_o = s_q.cur.src;
  assign exec_len_o = s_q.cur.len;
  assign exec_text_o = s_q.cur.text;
  assign tx_valid_o = s_q.tx_valid;
  assign tx_data_o = s_q.tx_data;
  assign tx_dst_o = s_q.tx_dst;
  assign esr_o = s_q.esr;
  assign err_valid_o = s_q.err;
  assign err_code_o = ERR_INPUT_OVERFLOW;

  // Fixed line settings for the two serial ports
  assign virtual_serial_port_bit_cycles_o =
    VIRTUAL_SERIAL_PORT_BIT_CYCLES;
  assign legacy_bit_cycles_o = LEGACY_BIT_CYCLES;
  assign uart_frame_o = {UART_DATA_BITS, UART_START_BITS,
                         UART_STOP_BITS[0], UART_PARITY_EN | UART_FLOW_EN};

endmodule : rfe_remote_front_end

//--- verification/rfe_host_model.sv
// Host-side model: collects reply bytes and can stall them
module rfe_host_model
  import rfe_pkg::*;
(
  // Clock and pacing mode
  input wire logic clk_i,
  input wire logic slow_i,
  // Reply bytes from the device
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic [SRC_W-1:0] tx_dst_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bytes arrive here already deframed; 8N1 line rates sit in the UARTs
  logic [11:0] got[$];
  logic tog = 1'b0;
  // Slow mode takes every other cycle so replies must be held
  assign tx_ready_o = !slow_i || tog;
  always @(posedge clk_i) begin
    tog <= !tog;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back({tx_dst_i, tx_data_i});
    end
  end
endmodule : rfe_host_model

//--- verification/rfe_remote_front_end_properties.sv
// Port assertions for the remote command front end
module rfe_remote_front_end_properties
  import rfe_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Connections
  input wire logic conn_open_i,
  input wire logic [15:0] conn_port_i,
  input wire logic [CONN_W-1:0] conn_id_i,
  input wire logic conn_accept_o,
  input wire logic conn_reject_o,
  input wire logic bcast_valid_o,
  input wire logic [CONN_W-1:0] bcast_conn_o,
  // Transmit and status
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic [SRC_W-1:0] tx_dst_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] esr_o,
  input wire logic esr_clear_i,
  input wire logic err_valid_o,
  input wire logic [15:0] err_code_o,
  input wire logic [15:0] virtual_serial_port_bit_cycles_o,
  input wire logic [15:0] legacy_bit_cycles_o,
  input wire logic [7:0] uart_frame_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic ok_port;
  assign ok_port = conn_port_i inside {16'h0017, 16'h1C0C, 16'h1C11};
  property p_accept;
    ce_i && conn_open_i && ok_port |=> conn_accept_o && !conn_reject_o;
  endproperty
  a_accept: assert property (p_accept)
    else $error("open on listed port not accepted");
  property p_reject;
    ce_i && conn_open_i && !ok_port |=> conn_reject_o && !conn_accept_o;
  endproperty
  a_reject: assert property (p_reject)
    else $error("open on other port not rejected");
  property p_bcast;
    ce_i && conn_open_i && conn_port_i == 16'h0017 |=>
      bcast_valid_o && bcast_conn_o == $past(conn_id_i);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast not on newest connection");
  property p_hold;
    tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o) && $stable(tx_dst_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled byte changed");
  property p_crlf;
    tx_valid_o && tx_ready_i && tx_data_o == 8'h0D |=>
      tx_valid_o && tx_data_o == 8'h0A && tx_dst_o == $past(tx_dst_o);
  endproperty
  a_crlf: assert property (p_crlf)
    else $error("carriage return not followed by line feed");
  property p_err;
    err_valid_o |-> err_code_o == 16'hFED1 ##[0:1] esr_o[4];
  endproperty
  a_err: assert property (p_err)
    else $error("overflow code or error bit wrong");
  // Set bits must survive until a clear request
  property p_sticky;
    !esr_clear_i |=> (esr_o & $past(esr_o)) == $past(esr_o);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit lost without clear");
  property p_cfg;
    virtual_serial_port_bit_cycles_o == 16'h00D9 &&
      legacy_bit_cycles_o == 16'h0364 && uart_frame_o == 8'h86;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("serial settings wrong");
  c_accept: cover property (conn_accept_o);
  c_err: cover property (err_valid_o);
  c_bcast: cover property (bcast_valid_o ##1 !bcast_valid_o);
endmodule : rfe_remote_front_end_properties

bind rfe_remote_front_end rfe_remote_front_end_properties i_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .conn_open_i(conn_open_i), .conn_port_i(conn_port_i),
  .conn_id_i(conn_id_i), .conn_accept_o(conn_accept_o),
  .conn_reject_o(conn_reject_o), .bcast_valid_o(bcast_valid_o),
  .bcast_conn_o(bcast_conn_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_dst_o(tx_dst_o), .tx_ready_i(tx_ready_i),
  .esr_o(esr_o), .esr_clear_i(esr_clear_i), .err_valid_o(err_valid_o),
  .err_code_o(err_code_o),
  .virtual_serial_port_bit_cycles_o(virtual_serial_port_bit_cycles_o),
  .legacy_bit_cycles_o(legacy_bit_cycles_o), .uart_frame_o(uart_frame_o)
);

//--- verification/tb.sv
// Self-checking bench for the remote command front end
module tb
  import rfe_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic [SRC_W-1:0] rx_src_i = 4'h0;
  logic conn_open_i = 1'b0;
  logic conn_close_i = 1'b0;
  logic [15:0] conn_port_i = 16'h0000;
  logic [CONN_W-1:0] conn_id_i = 3'h0;
  logic exec_ready_i = 1'b1;
  logic esr_clear_i = 1'b0;
  logic slow = 1'b0;
  logic ce_i = 1'b1;
  logic exec_reply_i = 1'b0;
  logic rsp_valid_i = 1'b0;
  logic [7:0] rsp_data_i = 8'h00;
  logic rsp_last_i = 1'b0;
  logic tx_ready_i, conn_accept_o, conn_reject_o, bcast_valid_o;
  logic exec_valid_o, rsp_ready_o, tx_valid_o, err_valid_o;
  logic [CONN_W-1:0] bcast_conn_o;
  logic [SRC_W-1:0] exec_src_o, tx_dst_o;
  logic [LEN_W-1:0] exec_len_o;
  logic [CMD_BYTES*8-1:0] exec_text_o;
  logic [7:0] tx_data_o, esr_o, uart_frame_o;
  logic [15:0] err_code_o, legacy_bit_cycles_o;
  logic [15:0] virtual_serial_port_bit_cycles_o;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int n_err = 0;
  int n_exec = 0;

  rfe_remote_front_end i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_src_i(rx_src_i),
    .conn_open_i(conn_open_i), .conn_close_i(conn_close_i),
    .conn_port_i(conn_port_i), .conn_id_i(conn_id_i),
    .conn_accept_o(conn_accept_o), .conn_reject_o(conn_reject_o),
    .bcast_valid_o(bcast_valid_o), .bcast_conn_o(bcast_conn_o),
    .exec_valid_o(exec_valid_o), .exec_src_o(exec_src_o),
    .exec_len_o(exec_len_o), .exec_text_o(exec_text_o),
    .exec_ready_i(exec_ready_i), .exec_reply_i(exec_reply_i),
    .rsp_valid_i(rsp_valid_i), .rsp_data_i(rsp_data_i),
    .rsp_last_i(rsp_last_i),
    .rsp_ready_o(rsp_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_dst_o(tx_dst_o), .tx_ready_i(tx_ready_i),
    .esr_o(esr_o), .esr_clear_i(esr_clear_i), .err_valid_o(err_valid_o),
    .err_code_o(err_code_o),
    .virtual_serial_port_bit_cycles_o(virtual_serial_port_bit_cycles_o),
    .legacy_bit_cycles_o(legacy_bit_cycles_o), .uart_frame_o(uart_frame_o)
  );
  rfe_host_model i_host (
    .clk_i(clk_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_dst_i(tx_dst_o), .tx_ready_o(tx_ready_i)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    n_err <= n_err + int'(err_valid_o === 1'b1);
    n_exec <= n_exec + int'(exec_valid_o === 1'b1 && exec_ready_i);
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic [SRC_W-1:0] src, input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid_i = 1'b1;
      rx_src_i = src;
      rx_data_i = 8'(s[i]);
      step();
    end
    rx_valid_i = 1'b0;
    step();
  endtask : send
  // Waits for a whole reply, then matches bytes and destination
  task automatic expect_tx(input logic [SRC_W-1:0] dst, input string s);
    int n;
    n = 0;
    while (i_host.got.size() < s.len() && n < 400) begin
      step();
      n++;
    end
    chk("reply count", s.len(), i_host.got.size());
    for (int i = 0; i < s.len(); i++) begin
      if (i_host.got.size() > 0) begin
        chk("reply byte", {dst, 8'(s[i])}, i_host.got.pop_front());
      end
    end
  endtask : expect_tx
  task automatic open_conn(input logic [15:0] port, input logic [2:0] id,
                           input logic acc);
    conn_open_i = 1'b1;
    conn_port_i = port;
    conn_id_i = id;
    step();
    conn_open_i = 1'b0;
    chk("accept", acc, conn_accept_o);
    chk("reject", !acc, conn_reject_o);
    step();
  endtask : open_conn

  task automatic t_reset();
    chk("esr", 8'h80, esr_o);
    chk("virtual serial bit cycles", 16'h00D9,
        virtual_serial_port_bit_cycles_o);
    chk("legacy bit cycles", 16'h0364, legacy_bit_cycles_o);
    chk("frame", 8'h86, uart_frame_o);
  endtask : t_reset
  // Each burst ends with a query round trip before more is sent
  task automatic t_query();
    send(SRC_VIRTUAL_SERIAL_PORT, "*opc?\r");
    expect_tx(SRC_VIRTUAL_SERIAL_PORT, "1\r\n");
    chk("opc bit", 1'b0, esr_o[0]);
    slow = 1'b1;
    send(SRC_LEGACY, "*OpC?\n\r*opc?\r\n*OPC?;");
    expect_tx(SRC_LEGACY, "1\r\n1\r\n1\r\n");
    slow = 1'b0;
  endtask : t_query
  task automatic t_order();
    exec_ready_i = 1'b0;
    send(SRC_VIRTUAL_SERIAL_PORT, "go;*opc\r");
    step(20);
    chk("opc early", 1'b0, esr_o[0]);
    chk("exec valid", 1'b1, exec_valid_o);
    chk("exec len", 5'h02, exec_len_o);
    chk("exec text", 16'h4F47, exec_text_o[15:0]);
    // A low clock enable must hold the waiting command in place
    ce_i = 1'b0;
    exec_ready_i = 1'b1;
    step(3);
    chk("frozen exec", 1'b1, exec_valid_o);
    chk("frozen opc", 1'b0, esr_o[0]);
    ce_i = 1'b1;
    step(20);
    chk("opc bit", 1'b1, esr_o[0]);
    chk("no echo", 0, i_host.got.size());
  endtask : t_order
  task automatic t_overflow();
    int e0;
    int x0;
    esr_clear_i = 1'b1;
    step();
    esr_clear_i = 1'b0;
    chk("esr cleared", 8'h00, esr_o);
    exec_ready_i = 1'b0;
    e0 = n_err;
    x0 = n_exec;
    send(SRC_VIRTUAL_SERIAL_PORT, "a;b;c;d;e;f;");
    step(10);
    chk("overflow pulses", 1, n_err - e0);
    chk("exec error bit", 1'b1, esr_o[4]);
    exec_ready_i = 1'b1;
    step(40);
    chk("executed", 5, n_exec - x0);
    chk("no echo", 0, i_host.got.size());
  endtask : t_overflow
  // Executor reply goes back to its source, then CR LF is appended
  task automatic t_reply();
    slow = 1'b1;
    exec_reply_i = 1'b1;
    send(SRC_LEGACY, "v?\r");
    chk("exec src", SRC_LEGACY, exec_src_o);
    for (int i = 0; i < 2; i++) begin
      rsp_valid_i = 1'b1;
      rsp_data_i = 8'h34 - 8'(i);
      rsp_last_i = (i == 1);
      while (rsp_ready_o !== 1'b1) begin
        step();
      end
      step();
    end
    rsp_valid_i = 1'b0;
    rsp_last_i = 1'b0;
    exec_reply_i = 1'b0;
    expect_tx(SRC_LEGACY, "43\r\n");
    chk("rsp ready idle", 1'b0, rsp_ready_o);
    slow = 1'b0;
  endtask : t_reply
  task automatic t_conn();
    open_conn(16'h1C0C, 3'h2, 1'b1);
    expect_tx(4'hA, "IP Interface\r\nHello.\r\n");
    open_conn(16'h0017, 3'h1, 1'b1);
    open_conn(16'h0017, 3'h3, 1'b1);
    chk("bcast conn", 3'h3, bcast_conn_o);
    open_conn(16'h1C0C, 3'h4, 1'b1);
    expect_tx(4'hC, "IP Interface\r\nHello.\r\n");
    send(4'hC, "*OPC?\r");
    expect_tx(4'hC, "1\r\n");
    open_conn(16'h1C11, 3'h5, 1'b1);
    open_conn(16'h0050, 3'h6, 1'b0);
    step(40);
    chk("quiet port", 0, i_host.got.size());
    conn_close_i = 1'b1;
    conn_id_i = 3'h3;
    step();
    conn_close_i = 1'b0;
    chk("bcast dropped", 1'b0, bcast_valid_o);
  endtask : t_conn

  initial begin
    step(10);
    resetn_i = 1'b1;
    step();
    t_reset();
    t_query();
    t_order();
    t_overflow();
    t_reply();
    t_conn();
    end_of_test();
  end
endmodule : tb
